/* File: rsc_defines.svh */
`ifndef RSC_DEFINES_SVH
`define RSC_DEFINES_SVH

// Clock rates and slow tick divider
`define RSC_CLK_HZ 125000000
`define RSC_SLOW_HZ 32768
`define RSC_TICK_DIV (`RSC_CLK_HZ / `RSC_SLOW_HZ)
`define RSC_TICK_W 12

// Register byte offsets
`define RSC_OFS_CMD 8'h00
`define RSC_OFS_STAT 8'h04
`define RSC_OFS_MODE 8'h08
`define RSC_OFS_MASK 8'h0c

// Write key field and value (value is arbitrary)
`define RSC_KEY_MSB 31
`define RSC_KEY_LSB 24
`define RSC_KEY_VALUE 8'h3c

// Command register bits
`define RSC_CMD_CPU 0
`define RSC_CMD_EXT 3

// Status register bits
`define RSC_STAT_SEEN 0
`define RSC_CAUSE_MSB 10
`define RSC_CAUSE_LSB 8
`define RSC_STAT_LEVEL 16
`define RSC_STAT_BUSY 17

// Mode register bits
`define RSC_MODE_EN 0
`define RSC_MODE_IEN 4
`define RSC_LEN_MSB 11
`define RSC_LEN_LSB 8

// Reset cause codes
`define RSC_CAUSE_NONE 3'h0
`define RSC_CAUSE_SOFT 3'h3
`define RSC_CAUSE_USER 3'h4

// Slow tick counts
`define RSC_USER_LOW_TICKS 4'h2
`define RSC_RESYNC_TICKS 4'h2
`define RSC_STARTUP_TICKS 4'h3
`define RSC_SOFT_TICKS 4'h3
`define RSC_CNT_ZERO 4'h0
`define RSC_CNT_ONE 4'h1

`endif

/* File: rsc_pkg.sv */
package rsc_pkg;

  typedef enum logic [2:0] {
    RSC_IDLE,
    RSC_SOFT,
    RSC_USER_WAIT,
    RSC_USER_HOLD,
    RSC_USER_RESYNC,
    RSC_USER_START
  } rsc_state_e;

  typedef logic [3:0] rsc_count_t;

endpackage

/* File: rsc_pin_sync.sv */
module rsc_pin_sync (
  input wire logic clk,
  input wire logic reset,
  input wire logic pin_i,
  output logic level_q
);

  logic ff1_q;
  logic ff2_q;
  logic ff3_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      ff1_q <= 1'b1;
      ff2_q <= 1'b1;
      ff3_q <= 1'b1;
    end else begin
      ff1_q <= pin_i;
      ff2_q <= ff1_q;
      ff3_q <= ff2_q;
    end
  end

  // Level changes only once two late stages agree
  always_ff @(posedge clk) begin
    if (reset) begin
      level_q <= 1'b1;
    end else if (ff2_q == ff3_q) begin
      level_q <= ff3_q;
    end
  end

endmodule

/* File: rsc_tick_gen.sv */
`include "rsc_defines.svh"
module rsc_tick_gen (
  input wire logic clk,
  input wire logic reset,
  output logic tick_q
);

  logic [`RSC_TICK_W-1:0] cnt_q;
  localparam logic [`RSC_TICK_W-1:0] LAST = `RSC_TICK_W'(`RSC_TICK_DIV - 1);

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (cnt_q == LAST) begin
      cnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + `RSC_TICK_W'(1);
      tick_q <= 1'b0;
    end
  end

endmodule

/* File: rsc_reset_ctrl.sv */
`include "rsc_defines.svh"
module rsc_reset_ctrl
  import rsc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic ext_reset_pin_i,
  output logic ext_reset_pin_o,
  output logic ext_reset_pin_oe,
  output logic cpu_reset,
  output logic periph_reset,
  output logic cpu_clk_en,
  output logic irq
);

  logic tick;
  logic pin_stable;
  logic pin_slow_q;

  rsc_tick_gen u_tick (
    .clk(clk),
    .reset(reset),
    .tick_q(tick)
  );

  rsc_pin_sync u_sync (
    .clk(clk),
    .reset(reset),
    .pin_i(ext_reset_pin_i),
    .level_q(pin_stable)
  );

  // Pin level as seen by the slow clock
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_slow_q <= 1'b1;
    end else if (tick) begin
      pin_slow_q <= pin_stable;
    end
  end

  // Bus handshake: one wait cycle per request
  logic req;
  logic acc;
  logic wr_acc;
  logic rd_acc;
  logic full_word;
  logic key_ok;

  assign req = avs_read | avs_write;
  assign acc = req & ~avs_waitrequest;
  assign wr_acc = acc & avs_write;
  assign rd_acc = acc & avs_read;
  assign full_word = (avs_byteenable == 4'hf);
  assign key_ok = (avs_writedata[`RSC_KEY_MSB:`RSC_KEY_LSB] == `RSC_KEY_VALUE);

  always_ff @(posedge clk) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~(req & avs_waitrequest);
    end
  end

  // Registers
  rsc_state_e state_q;
  rsc_count_t cnt_q;
  logic busy_q;
  logic soft_cpu_q;
  logic drive_q;
  rsc_count_t len_cnt_q;
  logic [2:0] cause_q;
  logic seen_q;
  logic mode_en_q;
  logic mode_ien_q;
  rsc_count_t mode_len_q;
  logic mask_q;

  // Mode register write
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_en_q <= 1'b0;
      mode_ien_q <= 1'b0;
      mode_len_q <= `RSC_CNT_ZERO;
    end else if (wr_acc && full_word && avs_address == `RSC_OFS_MODE && key_ok) begin
      mode_en_q <= avs_writedata[`RSC_MODE_EN];
      mode_ien_q <= avs_writedata[`RSC_MODE_IEN];
      mode_len_q <= avs_writedata[`RSC_LEN_MSB:`RSC_LEN_LSB];
    end
  end

  // Interrupt mask register, no key needed
  always_ff @(posedge clk) begin
    if (reset) begin
      mask_q <= 1'b0;
    end else if (wr_acc && full_word && avs_address == `RSC_OFS_MASK) begin
      mask_q <= avs_writedata[`RSC_STAT_SEEN];
    end
  end

  // Command decode; user resets in flight also block it
  logic cmd_cpu;
  logic cmd_ext;
  logic cmd_go;

  assign cmd_cpu = avs_writedata[`RSC_CMD_CPU];
  assign cmd_ext = avs_writedata[`RSC_CMD_EXT];
  assign cmd_go = wr_acc && full_word && avs_address == `RSC_OFS_CMD && key_ok
    && !busy_q && state_q == RSC_IDLE && (cmd_cpu || cmd_ext);

  // Sequence events
  logic cnt_done;
  logic pin_low_idle;
  logic enter_hold;
  logic hold_exit;
  logic user_done;
  logic soft_done;

  assign cnt_done = (cnt_q == `RSC_CNT_ZERO);
  // Own drive and soft reset mask the pin, so self-made edges are not user resets
  assign pin_low_idle = tick && state_q == RSC_IDLE && !pin_slow_q && !drive_q && !cmd_go;
  assign enter_hold = tick && state_q == RSC_USER_WAIT && cnt_done;
  assign hold_exit = tick && state_q == RSC_USER_HOLD && pin_slow_q;
  assign user_done = tick && state_q == RSC_USER_START && cnt_done;
  assign soft_done = tick && state_q == RSC_SOFT && !drive_q && pin_slow_q && cnt_done;

  // Sequencer
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= RSC_IDLE;
      cnt_q <= `RSC_CNT_ZERO;
    end else begin
      unique case (state_q)
        RSC_IDLE: begin
          if (cmd_go) begin
            state_q <= RSC_SOFT;
            cnt_q <= `RSC_SOFT_TICKS - `RSC_CNT_ONE;
          end else if (pin_low_idle && mode_en_q) begin
            state_q <= RSC_USER_WAIT;
            cnt_q <= `RSC_USER_LOW_TICKS - `RSC_CNT_ONE;
          end
        end
        RSC_SOFT: begin
          // Counting waits for the line to read high again
          if (tick && !drive_q && pin_slow_q) begin
            if (cnt_done) begin
              state_q <= RSC_IDLE;
            end else begin
              cnt_q <= cnt_q - `RSC_CNT_ONE;
            end
          end
        end
        RSC_USER_WAIT: begin
          // A brief low still completes once detected
          if (tick) begin
            if (cnt_done) begin
              state_q <= RSC_USER_HOLD;
            end else begin
              cnt_q <= cnt_q - `RSC_CNT_ONE;
            end
          end
        end
        RSC_USER_HOLD: begin
          if (hold_exit) begin
            state_q <= RSC_USER_RESYNC;
            cnt_q <= `RSC_RESYNC_TICKS - `RSC_CNT_ONE;
          end
        end
        RSC_USER_RESYNC: begin
          if (tick) begin
            if (cnt_done) begin
              state_q <= RSC_USER_START;
              cnt_q <= `RSC_STARTUP_TICKS - `RSC_CNT_ONE;
            end else begin
              cnt_q <= cnt_q - `RSC_CNT_ONE;
            end
          end
        end
        RSC_USER_START: begin
          if (tick) begin
            if (cnt_done) begin
              state_q <= RSC_IDLE;
            end else begin
              cnt_q <= cnt_q - `RSC_CNT_ONE;
            end
          end
        end
      endcase
    end
  end

  // Internal resets: set at once on a soft write with the CPU bit or on the user hold tick, cleared on a slow tick
  always_ff @(posedge clk) begin
    if (reset) begin
      cpu_reset <= 1'b0;
      periph_reset <= 1'b0;
    end else if (cmd_go && cmd_cpu) begin
      cpu_reset <= 1'b1;
      periph_reset <= 1'b1;
    end else if (enter_hold) begin
      cpu_reset <= 1'b1;
      periph_reset <= 1'b1;
    end else if (soft_done || user_done) begin
      cpu_reset <= 1'b0;
      periph_reset <= 1'b0;
    end
  end

  // Processor clock gate
  always_ff @(posedge clk) begin
    if (reset) begin
      cpu_clk_en <= 1'b1;
    end else if (enter_hold) begin
      cpu_clk_en <= 1'b0;
    end else if (hold_exit) begin
      cpu_clk_en <= 1'b1;
    end
  end

  // Busy flag and kind of the running soft reset
  always_ff @(posedge clk) begin
    if (reset) begin
      busy_q <= 1'b0;
      soft_cpu_q <= 1'b0;
    end else if (cmd_go) begin
      busy_q <= 1'b1;
      soft_cpu_q <= cmd_cpu;
    end else if (soft_done) begin
      busy_q <= 1'b0;
    end
  end

  // Line driver; released on the (length+1)th slow tick after the write, so the first tick may be partial
  always_ff @(posedge clk) begin
    if (reset) begin
      drive_q <= 1'b0;
      len_cnt_q <= `RSC_CNT_ZERO;
    end else if (cmd_go && cmd_ext) begin
      drive_q <= 1'b1;
      len_cnt_q <= mode_len_q;
    end else if (tick && drive_q) begin
      if (len_cnt_q == `RSC_CNT_ZERO) begin
        drive_q <= 1'b0;
      end else begin
        len_cnt_q <= len_cnt_q - `RSC_CNT_ONE;
      end
    end
  end

  // Open-drain pin: only ever pulls low
  always_ff @(posedge clk) begin
    if (reset) begin
      ext_reset_pin_o <= 1'b0;
    end else begin
      ext_reset_pin_o <= 1'b0;
    end
  end

  assign ext_reset_pin_oe = drive_q;

  // Reset cause code
  always_ff @(posedge clk) begin
    if (reset) begin
      cause_q <= `RSC_CAUSE_NONE;
    end else if (user_done) begin
      cause_q <= `RSC_CAUSE_USER;
    end else if (soft_done && soft_cpu_q) begin
      cause_q <= `RSC_CAUSE_SOFT;
    end
  end

  // Sticky seen flag: set beats a clearing status read
  logic stat_rd;
  assign stat_rd = rd_acc && avs_address == `RSC_OFS_STAT;

  always_ff @(posedge clk) begin
    if (reset) begin
      seen_q <= 1'b0;
    end else if (pin_low_idle && !mode_en_q) begin
      seen_q <= 1'b1;
    end else if (stat_rd) begin
      seen_q <= 1'b0;
    end
  end

  // Level interrupt
  always_ff @(posedge clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= seen_q && mode_ien_q && mask_q;
    end
  end

  // Read data built while the request waits
  logic [31:0] rd_word;

  always_comb begin
    rd_word = '0;
    unique case (avs_address)
      `RSC_OFS_STAT: begin
        rd_word[`RSC_STAT_SEEN] = seen_q;
        rd_word[`RSC_CAUSE_MSB:`RSC_CAUSE_LSB] = cause_q;
        rd_word[`RSC_STAT_LEVEL] = pin_slow_q;
        rd_word[`RSC_STAT_BUSY] = busy_q;
      end
      `RSC_OFS_MODE: begin
        rd_word[`RSC_MODE_EN] = mode_en_q;
        rd_word[`RSC_MODE_IEN] = mode_ien_q;
        rd_word[`RSC_LEN_MSB:`RSC_LEN_LSB] = mode_len_q;
      end
      `RSC_OFS_MASK: begin
        rd_word[`RSC_STAT_SEEN] = mask_q;
      end
      default: begin
        rd_word = '0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      avs_readdata <= '0;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= rd_word;
    end
  end

endmodule

/* File: rsc_line_model.sv */
module rsc_line_model (
  input wire logic pin_o,
  input wire logic pin_oe,
  input wire logic press,
  output logic line
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pull-up: a released line reads high; a button press pulls it low for as long as press is held
  assign line = ~(pin_oe & ~pin_o) & ~press;
endmodule

/* File: rsc_reset_ctrl_asserts.sv */
`include "rsc_defines.svh"
module rsc_reset_ctrl_asserts (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic ext_reset_pin_i,
  input wire logic ext_reset_pin_oe,
  input wire logic cpu_reset,
  input wire logic periph_reset,
  input wire logic cpu_clk_en,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic acc_cmd;
  logic key_ok;
  assign acc_cmd = avs_write & ~avs_waitrequest & (avs_address == `RSC_OFS_CMD)
    & (avs_byteenable == 4'hf);
  assign key_ok = avs_writedata[31:24] == `RSC_KEY_VALUE;
  property p_same; periph_reset == cpu_reset; endproperty
  a_same: assert property (p_same) else $error("resets differ");
  property p_soft; $rose(cpu_reset) && cpu_clk_en |-> $past(acc_cmd && key_ok && avs_writedata[0]);
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset without command");
  property p_ext; $rose(ext_reset_pin_oe) |-> $past(acc_cmd && key_ok && avs_writedata[3]);
  endproperty
  a_ext: assert property (p_ext) else $error("line driven without command");
  property p_key; acc_cmd && !key_ok |=> !$rose(ext_reset_pin_oe) && !($rose(cpu_reset) && cpu_clk_en);
  endproperty
  a_key: assert property (p_key) else $error("bad key obeyed");
  property p_busy; acc_cmd && (cpu_reset || ext_reset_pin_oe)
    |=> !$rose(ext_reset_pin_oe) && !$rose(cpu_reset); endproperty
  a_busy: assert property (p_busy) else $error("command taken while busy");
  property p_low; !ext_reset_pin_i && cpu_reset |=> cpu_reset; endproperty
  a_low: assert property (p_low) else $error("reset released with line low");
  property p_clk; $rose(cpu_clk_en) |-> cpu_reset; endproperty
  a_clk: assert property (p_clk) else $error("clock back after reset end");
  property p_start; $rose(cpu_clk_en) |=> cpu_reset [*8]; endproperty
  a_start: assert property (p_start) else $error("startup delay short");
  property p_len; $rose(ext_reset_pin_oe) |=> ext_reset_pin_oe [*8]; endproperty
  a_len: assert property (p_len) else $error("line pulse short");
  property p_irq; $rose(irq) |-> !cpu_reset; endproperty
  a_irq: assert property (p_irq) else $error("irq during reset");
  c_soft: cover property ($rose(cpu_reset) && cpu_clk_en);
  c_user: cover property ($fell(cpu_clk_en));
  c_irq: cover property ($rose(irq));
endmodule
bind rsc_reset_ctrl rsc_reset_ctrl_asserts u_rsc_reset_ctrl_asserts (.clk(clk), .reset(reset),
  .avs_address(avs_address), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
  .ext_reset_pin_i(ext_reset_pin_i), .ext_reset_pin_oe(ext_reset_pin_oe), .cpu_reset(cpu_reset),
  .periph_reset(periph_reset), .cpu_clk_en(cpu_clk_en), .irq(irq));

/* File: rsc_reset_ctrl_tb.sv */
`include "rsc_defines.svh"
module rsc_reset_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = `RSC_TICK_DIV;
  localparam logic [31:0] KEY = 32'h3c000000;
  logic clk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0, press = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, s;
  logic [3:0] avs_byteenable = 4'hf;
  logic avs_waitrequest, line, pin_o, pin_oe, cpu_reset, periph_reset, cpu_clk_en, irq;
  int n_mismatch = 0, n_tests = 0, t;
  always #4 clk = ~clk;
  rsc_reset_ctrl u_rsc_reset_ctrl (.clk(clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ext_reset_pin_i(line), .ext_reset_pin_o(pin_o),
    .ext_reset_pin_oe(pin_oe), .cpu_reset(cpu_reset), .periph_reset(periph_reset),
    .cpu_clk_en(cpu_clk_en), .irq(irq));
  rsc_line_model u_rsc_line_model (.pin_o(pin_o), .pin_oe(pin_oe), .press(press), .line(line));
  task automatic conclude;
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  task automatic chk1(input logic g, input logic e, input string m);
    chk({31'h0, g}, {31'h0, e}, m);
  endtask
  task automatic range(input int lo, input int hi, input string m);
    chk1(t >= lo && t <= hi, 1'b1, m);
  endtask
  // One request; a bounded wait stands in for a hung slave
  task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= rd;
    avs_write <= !rd;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    s = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) begin
      chk1(1'b0, 1'b1, "bus timeout");
      conclude();
    end
  endtask
  task automatic wsig(input int sel, input logic v, input int lim);
    t = 0;
    while ((sel == 0 ? cpu_reset : sel == 1 ? pin_oe : cpu_clk_en) !== v) begin
      @(posedge clk);
      t++;
      if (t > lim) begin
        chk1(1'b0, 1'b1, "wait timeout");
        conclude();
      end
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    bus(1'b1, 8'h08, 32'h0);
    chk(s, 32'h0, "mode reset value");
    bus(1'b1, 8'h04, 32'h0);
    chk(s, 32'h00010000, "status reset value");
    bus(1'b1, 8'h10, 32'h0);
    chk(s, 32'h0, "unmapped read");
    bus(1'b0, 8'h08, 32'h00000111);
    bus(1'b1, 8'h08, 32'h0);
    chk(s, 32'h0, "bad key taken");
    bus(1'b0, 8'h08, KEY | 32'h110);
    bus(1'b1, 8'h08, 32'h0);
    chk(s, 32'h110, "mode readback");
    bus(1'b0, 8'h0c, 32'h1);
    bus(1'b0, 8'h00, 32'h00000009);
    @(posedge clk);
    chk1(cpu_reset | pin_oe, 1'b0, "bad key command");
    bus(1'b0, 8'h00, KEY | 32'h8);
    wsig(1, 1'b1, 4);
    chk1(pin_o | line, 1'b0, "line not pulled low");
    bus(1'b0, 8'h00, KEY | 32'h1);
    bus(1'b1, 8'h04, 32'h0);
    chk(s & 32'h00020701, 32'h00020000, "ext busy status");
    chk1(cpu_reset, 1'b0, "command taken while busy");
    wsig(1, 1'b0, 3 * TK);
    range(TK - 20, 2 * TK + 2, "line length");
    // Long wait lets busy clear after the line returns high
    repeat (4 * TK + 10) @(posedge clk);
    chk1(irq, 1'b0, "own edge seen");
    bus(1'b1, 8'h04, 32'h0);
    chk(s & 32'h00020701, 32'h00000000, "ext only status");
    bus(1'b0, 8'h00, KEY | 32'h1);
    wsig(0, 1'b1, 3);
    bus(1'b1, 8'h04, 32'h0);
    chk(s & 32'h00020000, 32'h00020000, "busy not set");
    wsig(0, 1'b0, 4 * TK);
    range(2 * TK, 3 * TK + 5, "soft release");
    bus(1'b1, 8'h04, 32'h0);
    chk(s & 32'h00020701, 32'h00000300, "soft status");
    press <= 1'b1;
    repeat (2 * TK) @(posedge clk);
    chk1(irq, 1'b1, "irq missing");
    chk1(cpu_reset, 1'b0, "reset while disabled");
    press <= 1'b0;
    repeat (2 * TK) @(posedge clk);
    bus(1'b1, 8'h04, 32'h0);
    chk(s & 32'h00010001, 32'h00010001, "seen or level");
    repeat (3) @(posedge clk);
    chk1(irq, 1'b0, "irq not cleared");
    bus(1'b0, 8'h08, KEY | 32'h111);
    press <= 1'b1;
    wsig(0, 1'b1, 5 * TK);
    // Low is latched a tick before it is detected
    range(3 * TK, 4 * TK + 10, "user assert time");
    chk1(cpu_clk_en, 1'b0, "clock not stopped");
    repeat (TK) @(posedge clk);
    chk1(cpu_reset, 1'b1, "released while low");
    press <= 1'b0;
    wsig(2, 1'b1, 2 * TK + 20);
    wsig(0, 1'b0, 6 * TK);
    range(5 * TK - 3, 5 * TK + 3, "user release time");
    bus(1'b1, 8'h04, 32'h0);
    chk(s & 32'h00000700, 32'h00000400, "user cause");
    conclude();
  end
endmodule
